// ==== rtl/ocs_pkg.sv ====
// constants and types shared by the oscillator source select block
package ocs_pkg;

    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam int unsigned ADDR_W      = 4;
    localparam int unsigned DATA_W      = 8;
    localparam logic [3:0]  OFS_SC      = 4'h0;
    localparam logic [3:0]  OFS_PIN     = 4'h1;

    // status and control fields
    localparam int unsigned OPT_LSB     = 6;
    localparam int unsigned INTERNAL_FREQ_SELECT_LSB    = 4;
    localparam int unsigned CRYSTAL_RANGE_SELECT_LSB    = 2;
    localparam int unsigned REQ_BIT     = 1;
    localparam int unsigned ENG_BIT     = 0;
    // pin control fields
    localparam int unsigned PIN_OE_BIT  = 0;

    // reset values
    localparam logic [1:0]  OPT_RST     = 2'h0;
    localparam logic [1:0]  INTERNAL_FREQ_SELECT_RST    = 2'h0;
    localparam logic [1:0]  CRYSTAL_RANGE_SELECT_RST    = 2'h0;
    localparam logic        REQ_RST     = 1'b0;
    localparam logic        PIN_OE_RST  = 1'b0;
    localparam logic [7:0]  RD_ZERO     = 8'h00;

    // -------------------------------------------------------------------
    // source codes
    // -------------------------------------------------------------------
    localparam logic [1:0]  SRC_INT     = 2'h0;
    localparam logic [1:0]  SRC_EXT     = 2'h1;
    localparam logic [1:0]  SRC_RC      = 2'h2;
    localparam logic [1:0]  SRC_XTAL    = 2'h3;

    // internal frequency codes: 4.0, 8.0, 12.8, 25.6 MHz
    localparam logic [1:0]  FREQ_4M0    = 2'h0;
    localparam logic [1:0]  FREQ_8M0    = 2'h1;
    localparam logic [1:0]  FREQ_12M8   = 2'h2;
    localparam logic [1:0]  FREQ_25M6   = 2'h3;

    // crystal ranges: 8-32 MHz, 1-8 MHz, 32-100 kHz, reserved
    localparam logic [1:0]  XR_HIGH     = 2'h0;
    localparam logic [1:0]  XR_MID      = 2'h1;
    localparam logic [1:0]  XR_LOW      = 2'h2;
    localparam logic [1:0]  XR_RSVD     = 2'h3;

    // rising edges of a new source seen before it is trusted
    localparam logic [1:0]  EDGE_CNT    = 2'h2;

    typedef enum logic [2:0] {
        ST_INT,
        ST_CHECK,
        ST_SWITCH,
        ST_EXT,
        ST_RESTART,
        ST_BACK
    } ocs_state_t;

endpackage

// ==== rtl/ocs_clock_select.sv ====
// oscillator source selection, switch-over handshake and pin assignment
`timescale 1ns/1ps
`default_nettype none

module ocs_clock_select (
    input  wire logic        clk_sys_i,          // system clock, 40 MHz
    input  wire logic        rst_i,              // async reset, active high
    input  wire logic [3:0]  reg_addr_i,         // register address
    input  wire logic [7:0]  reg_wdata_i,        // register write data
    input  wire logic        reg_wr_i,           // write strobe
    input  wire logic        reg_rd_i,           // read strobe
    output logic      [7:0]  reg_rdata_o,        // read data, cycle after strobe
    input  wire logic        int_osc_clk_i,      // internal oscillator output
    input  wire logic        rc_osc_clk_i,       // RC oscillator output
    input  wire logic        xtal_osc_clk_i,     // crystal oscillator output
    input  wire logic        clock_in_pin_i,     // clock input pin level
    input  wire logic        monitor_bypass_i,   // monitor mode, internal osc bypassed
    input  wire logic        keep_osc_in_stop_i, // configuration: run in stop
    input  wire logic        system_osc_enable_i,// oscillator enable from integration unit
    output logic             clock_in_pin_use_o, // input pin owned by oscillator
    output logic             clock_aux_pin_o,    // aux pin output value
    output logic             clock_aux_pin_oe_n_o, // aux pin drive, active low
    output logic             aux_pin_xtal_o,     // aux pin dedicated to crystal
    output logic             aux_pin_port_o,     // aux pin free for port function
    output logic      [1:0]  internal_freq_select_o, // internal oscillator frequency
    output logic             int_osc_en_o,       // internal oscillator run
    output logic             rc_osc_en_o,        // RC oscillator run
    output logic      [2:0]  xtal_amp_en_o,      // crystal amplifier enables
    output logic             bus_clock_x4_o,     // clock at source rate
    output logic             bus_clock_x2_o,     // clock at half source rate
    output logic             irq_o               // interrupt request, never raised
);

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    logic [1:0]         opt_q;
    logic [1:0]         internal_freq_select_q;
    logic [1:0]         crystal_range_select_q;
    logic               req_q;
    logic               eng_q;
    logic               pin_oe_q;
    logic [7:0]         rdata_q;
    ocs_pkg::ocs_state_t state_q;
    logic [1:0]         edge_cnt_q;
    logic               sel_ext_q;
    logic               ext_prev_q;
    logic               int_prev_q;
    logic               x4_q;
    logic               x2_q;

    logic               wr_sc;
    logic               wr_pin;
    logic               req_eff;
    logic               osc_run;
    logic               ext_src;
    logic               ext_rise;
    logic               int_rise;
    logic               src_is_ext;
    logic               pin_drive;

    assign wr_sc  = reg_wr_i && (reg_addr_i == ocs_pkg::OFS_SC);
    assign wr_pin = reg_wr_i && (reg_addr_i == ocs_pkg::OFS_PIN);

    // monitor bypass masks the request without altering the stored bit
    assign req_eff = req_q && !monitor_bypass_i;

    // wait mode is not an input: nothing here slows or stops in wait
    assign osc_run = system_osc_enable_i || keep_osc_in_stop_i;

    // -------------------------------------------------------------------
    // status and control register
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            opt_q  <= ocs_pkg::OPT_RST;
            internal_freq_select_q <= ocs_pkg::INTERNAL_FREQ_SELECT_RST;
            crystal_range_select_q <= ocs_pkg::CRYSTAL_RANGE_SELECT_RST;
            req_q  <= ocs_pkg::REQ_RST;
        end
        else if (wr_sc)
        begin
            opt_q  <= reg_wdata_i[ocs_pkg::OPT_LSB +: 2];
            internal_freq_select_q <= reg_wdata_i[ocs_pkg::INTERNAL_FREQ_SELECT_LSB +: 2];
            crystal_range_select_q <= reg_wdata_i[ocs_pkg::CRYSTAL_RANGE_SELECT_LSB +: 2];
            req_q  <= reg_wdata_i[ocs_pkg::REQ_BIT];
        end
    end

    // clock-out enable; held clear while the external clock mode is chosen
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            pin_oe_q <= ocs_pkg::PIN_OE_RST;
        else if (opt_q == ocs_pkg::SRC_EXT)
            pin_oe_q <= 1'b0;
        else if (wr_pin)
            pin_oe_q <= reg_wdata_i[ocs_pkg::PIN_OE_BIT];
    end

    // -------------------------------------------------------------------
    // read port
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_q <= ocs_pkg::RD_ZERO;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                ocs_pkg::OFS_SC:  rdata_q <= {opt_q, internal_freq_select_q, crystal_range_select_q, req_q, eng_q};
                ocs_pkg::OFS_PIN: rdata_q <= {7'h00, pin_oe_q};
                default:          rdata_q <= ocs_pkg::RD_ZERO;
            endcase
        end
        else
            rdata_q <= ocs_pkg::RD_ZERO;
    end

    assign reg_rdata_o = rdata_q;

    // -------------------------------------------------------------------
    // source sampling
    // -------------------------------------------------------------------
    always_comb
    begin
        case (opt_q)
            ocs_pkg::SRC_EXT:  ext_src = clock_in_pin_i;
            ocs_pkg::SRC_RC:   ext_src = rc_osc_clk_i;
            ocs_pkg::SRC_XTAL: ext_src = xtal_osc_clk_i;
            default:           ext_src = 1'b0;
        endcase
    end

    assign src_is_ext = (opt_q != ocs_pkg::SRC_INT);

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ext_prev_q <= 1'b0;
            int_prev_q <= 1'b0;
        end
        else
        begin
            ext_prev_q <= ext_src;
            int_prev_q <= int_osc_clk_i;
        end
    end

    assign ext_rise = ext_src && !ext_prev_q;
    assign int_rise = int_osc_clk_i && !int_prev_q;

    // -------------------------------------------------------------------
    // switch-over sequencer
    // -------------------------------------------------------------------
    // both directions wait for two edges of the incoming clock so a dead
    // source never takes over, then swap only while both clocks are low
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q    <= ocs_pkg::ST_INT;
            edge_cnt_q <= 2'h0;
            sel_ext_q  <= 1'b0;
            eng_q      <= 1'b0;
        end
        else
        begin
            case (state_q)
                ocs_pkg::ST_INT:
                begin
                    edge_cnt_q <= 2'h0;
                    if (req_eff && src_is_ext)
                    begin
                        state_q <= ocs_pkg::ST_CHECK;
                    end
                end
                ocs_pkg::ST_CHECK:
                begin
                    if (!req_eff || !src_is_ext)
                    begin
                        state_q <= ocs_pkg::ST_INT;
                    end
                    else if (edge_cnt_q == ocs_pkg::EDGE_CNT)
                    begin
                        state_q <= ocs_pkg::ST_SWITCH;
                    end
                    else if (ext_rise)
                    begin
                        edge_cnt_q <= edge_cnt_q + 2'h1;
                    end
                end
                ocs_pkg::ST_SWITCH:
                begin
                    if (!req_eff || !src_is_ext)
                    begin
                        state_q <= ocs_pkg::ST_INT;
                    end
                    else if (!x4_q && !ext_src)
                    begin
                        sel_ext_q <= 1'b1;
                        eng_q     <= 1'b1;
                        state_q   <= ocs_pkg::ST_EXT;
                    end
                end
                ocs_pkg::ST_EXT:
                begin
                    edge_cnt_q <= 2'h0;
                    if (!req_eff && !src_is_ext)
                    begin
                        state_q <= ocs_pkg::ST_RESTART;
                    end
                end
                ocs_pkg::ST_RESTART:
                begin
                    if (edge_cnt_q == ocs_pkg::EDGE_CNT)
                        state_q <= ocs_pkg::ST_BACK;
                    else if (int_rise)
                        edge_cnt_q <= edge_cnt_q + 2'h1;
                end
                ocs_pkg::ST_BACK:
                begin
                    if (!x4_q && !int_osc_clk_i)
                    begin
                        sel_ext_q <= 1'b0;
                        eng_q     <= 1'b0;
                        state_q   <= ocs_pkg::ST_INT;
                    end
                end
                default: state_q <= ocs_pkg::ST_INT;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // bus clocks
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            x4_q <= 1'b0;
        else if (!osc_run)
            x4_q <= 1'b0;
        else
            x4_q <= sel_ext_q ? ext_src : int_osc_clk_i;
    end

    // halves x4 by toggling on each of its rising edges
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            x2_q <= 1'b0;
        else if (osc_run && !x4_q && (sel_ext_q ? ext_src : int_osc_clk_i))
            x2_q <= !x2_q;
    end

    assign bus_clock_x4_o = x4_q;
    assign bus_clock_x2_o = x2_q;

    // -------------------------------------------------------------------
    // oscillator enables and pins
    // -------------------------------------------------------------------
    // internal oscillator stays on until the external source is engaged
    assign int_osc_en_o  = osc_run && (state_q != ocs_pkg::ST_EXT);
    assign rc_osc_en_o   = osc_run && (opt_q == ocs_pkg::SRC_RC);
    always_comb
    begin
        xtal_amp_en_o = 3'h0;
        if (osc_run && (opt_q == ocs_pkg::SRC_XTAL) && (crystal_range_select_q != ocs_pkg::XR_RSVD))
        begin
            xtal_amp_en_o[crystal_range_select_q] = 1'b1;
        end
    end

    assign internal_freq_select_o = internal_freq_select_q;

    // pin claimed by any external choice or by a pending request
    assign clock_in_pin_use_o = src_is_ext || req_q;

    assign aux_pin_xtal_o = (opt_q == ocs_pkg::SRC_XTAL);
    assign pin_drive = pin_oe_q && ((opt_q == ocs_pkg::SRC_INT) ||
                                    (opt_q == ocs_pkg::SRC_RC));
    assign aux_pin_port_o       = !aux_pin_xtal_o && !pin_drive;
    assign clock_aux_pin_oe_n_o = !pin_drive;
    assign clock_aux_pin_o      = pin_drive && x4_q;

    assign irq_o = 1'b0;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    sequence seq_counted;
        state_q == ocs_pkg::ST_CHECK && edge_cnt_q == ocs_pkg::EDGE_CNT;
    endsequence

    sequence seq_engage;
        state_q == ocs_pkg::ST_SWITCH ##1 eng_q;
    endsequence

    eng_after_edges_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(eng_q) |-> $past(state_q) == ocs_pkg::ST_SWITCH && edge_cnt_q == ocs_pkg::EDGE_CNT)
        else $error("engaged without two source edges");
    count_done_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        seq_counted |=> state_q == ocs_pkg::ST_SWITCH || state_q == ocs_pkg::ST_INT)
        else $error("counted edges did not lead to switch");
    switch_order_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        seq_engage |-> !int_osc_en_o || !osc_run)
        else $error("internal oscillator still on after engage");
    int_kept_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (osc_run && !int_osc_en_o) |-> eng_q && sel_ext_q)
        else $error("internal oscillator stopped before engage");
    ext_oe_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        opt_q == ocs_pkg::SRC_EXT |=> !pin_oe_q && clock_aux_pin_oe_n_o)
        else $error("clock-out enable not forced clear");
    xtal_aux_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        opt_q == ocs_pkg::SRC_XTAL |-> clock_aux_pin_oe_n_o && !aux_pin_port_o)
        else $error("aux pin not dedicated to crystal");
    aux_output_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (pin_oe_q && opt_q[0] == 1'b0) |-> !clock_aux_pin_oe_n_o
            && clock_aux_pin_o == bus_clock_x4_o)
        else $error("aux pin not carrying x4 clock");
    pin_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (opt_q == ocs_pkg::SRC_INT && !req_q) |-> !clock_in_pin_use_o)
        else $error("input pin not released");
    x2_half_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(x4_q) |-> x2_q != $past(x2_q))
        else $error("x2 clock did not toggle on x4 rise");
    bypass_ignore_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (monitor_bypass_i && state_q == ocs_pkg::ST_INT) |=> state_q == ocs_pkg::ST_INT)
        else $error("request honoured under monitor bypass");
    back_internal_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(eng_q) |-> !sel_ext_q && $past(state_q) == ocs_pkg::ST_BACK && int_osc_en_o)
        else $error("return to internal not orderly");
    stop_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !osc_run |-> !int_osc_en_o && !rc_osc_en_o && xtal_amp_en_o == 3'h0 ##1 !x4_q)
        else $error("oscillator running with enable low");

endmodule

`default_nettype wire

// ==== verification/ocs_osc_model.sv ====
// behavioural oscillators and external clock source around the select block
`timescale 1ns/1ps
`default_nettype none

module ocs_osc_model #(
    parameter int EXT_HALF = 125    // external clock half period in ns, slow or prompt
) (
    input  wire logic       int_en_i,   // internal oscillator run
    input  wire logic       rc_en_i,    // rc oscillator run
    input  wire logic [2:0] amp_en_i,   // crystal amplifier enables
    output logic            int_clk_o,  // internal oscillator output
    output logic            rc_clk_o,   // rc oscillator output
    output logic            xtal_clk_o, // crystal oscillator output
    output logic            ext_clk_o   // external clock on the input pin
);
    // -------------------------------------------------------------------
    // oscillators
    // -------------------------------------------------------------------
    // edges fall on multiples of 25 ns, never on a sampling edge
    // a stopped oscillator sits low instead of holding a stale phase
    initial
    begin
        int_clk_o = 1'b0;
        forever #100 int_clk_o = int_en_i & ~int_clk_o;
    end
    initial
    begin
        rc_clk_o = 1'b0;
        forever #75 rc_clk_o = rc_en_i & ~rc_clk_o;
    end
    initial
    begin
        xtal_clk_o = 1'b0;
        forever #150 xtal_clk_o = (|amp_en_i) & ~xtal_clk_o;
    end
    initial
    begin
        ext_clk_o = 1'b0;
        forever #(EXT_HALF) ext_clk_o = ~ext_clk_o;
    end
endmodule

`default_nettype wire

// ==== verification/ocs_clock_select_tb.sv ====
// self-checking bench for the oscillator source select block
`timescale 1ns/1ps
`default_nettype none

module ocs_clock_select_tb;
    logic       clk_sys_i, rst_i, reg_wr_i, reg_rd_i;
    logic [3:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, d, seed;
    logic       int_clk, rc_clk, xtal_clk, clock_in_pin_i;
    logic       monitor_bypass_i, keep_osc_in_stop_i, system_osc_enable_i;
    logic       clock_in_pin_use_o, clock_aux_pin_o, clock_aux_pin_oe_n_o;
    logic       aux_pin_xtal_o, aux_pin_port_o, int_osc_en_o, rc_osc_en_o;
    logic       bus_clock_x4_o, bus_clock_x2_o, irq_o, p4, p2;
    logic [1:0] internal_freq_select_o;
    logic [2:0] xtal_amp_en_o;
    int         num_errors, checked, i, x4r, x2t;
    int         m_sel, m_internal_freq_select, m_crystal_range_select, m_req, m_eng, m_pen;

    ocs_clock_select u_ocs_clock_select (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .int_osc_clk_i(int_clk),
        .rc_osc_clk_i(rc_clk), .xtal_osc_clk_i(xtal_clk), .clock_in_pin_i(clock_in_pin_i),
        .monitor_bypass_i(monitor_bypass_i), .keep_osc_in_stop_i(keep_osc_in_stop_i),
        .system_osc_enable_i(system_osc_enable_i), .clock_in_pin_use_o(clock_in_pin_use_o),
        .clock_aux_pin_o(clock_aux_pin_o), .clock_aux_pin_oe_n_o(clock_aux_pin_oe_n_o),
        .aux_pin_xtal_o(aux_pin_xtal_o), .aux_pin_port_o(aux_pin_port_o),
        .internal_freq_select_o(internal_freq_select_o), .int_osc_en_o(int_osc_en_o),
        .rc_osc_en_o(rc_osc_en_o), .xtal_amp_en_o(xtal_amp_en_o),
        .bus_clock_x4_o(bus_clock_x4_o), .bus_clock_x2_o(bus_clock_x2_o), .irq_o(irq_o));

    ocs_osc_model u_ocs_osc_model (.int_en_i(int_osc_en_o), .rc_en_i(rc_osc_en_o),
        .amp_en_i(xtal_amp_en_o), .int_clk_o(int_clk), .rc_clk_o(rc_clk),
        .xtal_clk_o(xtal_clk), .ext_clk_o(clock_in_pin_i));

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [7:0] exp_sc();
        return {2'(m_sel), 2'(m_internal_freq_select), 2'(m_crystal_range_select), 1'(m_req), 1'(m_eng)};
    endfunction

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t pin level %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        reg_addr_i  <= a;
        reg_wdata_i <= v;
        reg_wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        if (a == ocs_pkg::OFS_SC)
        begin
            m_sel  = v[7:6];
            m_internal_freq_select = v[5:4];
            m_crystal_range_select = v[3:2];
            m_req  = v[1];
            if (m_sel == 1)
                m_pen = 0;
        end
        else if (a == ocs_pkg::OFS_PIN)
            m_pen = (m_sel == 1) ? 0 : int'(v[0]);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        v = reg_rdata_o;
    endtask

    task automatic chk_pins();
        logic drv;
        drv = (m_pen != 0) && (m_sel == 0 || m_sel == 2);
        chk_pin(clock_aux_pin_oe_n_o, !drv);
        chk_pin(clock_aux_pin_o, drv && bus_clock_x4_o);
        chk_pin(aux_pin_xtal_o, m_sel == 3);
        chk_pin(aux_pin_port_o, !drv && m_sel != 3);
        chk_pin(clock_in_pin_use_o, m_sel != 0 || m_req != 0);
        chk_pin(rc_osc_en_o, m_sel == 2);
        chk_pin(irq_o, 1'b0);
    endtask

    // polls the engaged bit; a stuck design runs out the count
    task automatic wait_eng(input logic v);
        logic [7:0] s;
        for (int n = 0; n < 100; n++)
        begin
            rd(ocs_pkg::OFS_SC, s);
            if (s[0] === v)
                break;
        end
        m_eng = v;
    endtask

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // -------------------------------------------------------------------
    // clock, reset and watchdog
    // -------------------------------------------------------------------
    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    initial
    begin
        #200000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end

    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    initial
    begin
        {rst_i, system_osc_enable_i} = 2'b11;
        {reg_wr_i, reg_rd_i, monitor_bypass_i, keep_osc_in_stop_i} = 4'h0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 8'h00;
        {num_errors, checked, m_sel, m_internal_freq_select, m_crystal_range_select, m_req, m_eng, m_pen} = '0;
        seed = 8'h42;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(ocs_pkg::OFS_SC, d);
        chk_reg(d, 8'h00);
        wr(4'h5, 8'hff);
        rd(4'h5, d);
        chk_reg(d, 8'h00);
        rd(ocs_pkg::OFS_SC, d);
        chk_reg(d, 8'h00);
        chk_pins();
        for (i = 0; i < 16; i++)
        begin
            seed = lfsr(seed);
            wr(ocs_pkg::OFS_SC, {i[1:0], seed[1:0], i[3:2], 2'b00});
            wr(ocs_pkg::OFS_PIN, 8'h01);
            rd(ocs_pkg::OFS_PIN, d);
            chk_reg(d, 8'(m_pen));
            rd(ocs_pkg::OFS_SC, d);
            chk_reg(d, exp_sc());
            chk_reg({6'h00, internal_freq_select_o}, 8'(m_internal_freq_select));
            chk_pins();
            if (m_sel == 3)
                chk_reg({5'h00, xtal_amp_en_o}, (m_crystal_range_select == 3) ? 8'h00 : 8'(1 << m_crystal_range_select));
        end
        wr(ocs_pkg::OFS_SC, 8'h02);
        repeat (40) @(posedge clk_sys_i);
        rd(ocs_pkg::OFS_SC, d);
        chk_reg(d, exp_sc());
        chk_pins();
        @(posedge clk_sys_i);
        monitor_bypass_i <= 1'b1;
        wr(ocs_pkg::OFS_SC, 8'h42);
        repeat (40) @(posedge clk_sys_i);
        rd(ocs_pkg::OFS_SC, d);
        chk_reg(d, exp_sc());
        chk_pin(int_osc_en_o, 1'b1);
        @(posedge clk_sys_i);
        monitor_bypass_i <= 1'b0;
        wait_eng(1'b1);
        rd(ocs_pkg::OFS_SC, d);
        chk_reg(d, exp_sc());
        chk_pin(int_osc_en_o, 1'b0);
        {p4, p2, x4r, x2t} = {bus_clock_x4_o, bus_clock_x2_o, 64'd0};
        for (i = 0; i < 200; i++)
        begin
            @(posedge clk_sys_i);
            #1;
            chk_pin(bus_clock_x4_o, clock_in_pin_i);
            x4r += int'(bus_clock_x4_o && !p4);
            x2t += int'(bus_clock_x2_o != p2);
            p4 = bus_clock_x4_o;
            p2 = bus_clock_x2_o;
        end
        chk_pin((x2t - x4r) inside {[-1:1]} && x4r > 10, 1'b1);
        wr(ocs_pkg::OFS_SC, 8'h00);
        wait_eng(1'b0);
        rd(ocs_pkg::OFS_SC, d);
        chk_reg(d, exp_sc());
        chk_pin(int_osc_en_o, 1'b1);
        chk_pins();
        @(posedge clk_sys_i);
        system_osc_enable_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk_pin(int_osc_en_o, 1'b0);
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_sys_i);
            #1;
            chk_pin(bus_clock_x4_o, 1'b0);
        end
        @(posedge clk_sys_i);
        keep_osc_in_stop_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk_pin(int_osc_en_o, 1'b1);
        conclude();
    end
endmodule

`default_nettype wire
